// ==== hw/bdo_pkg.sv ====
// Package for the buzzer divider output block
// Assumes a 100 MHz system clock and an APB register bus
package bdo_pkg;
  // ==========================================================
  // Register map
  localparam logic [11:0] ADDR_CONTROL = 12'h038;
  localparam logic [11:0] ADDR_MODE = 12'h03c;
  localparam int CONTROL_WIDTH = 8;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam int BIT_ENABLE = 2;
  localparam int RATE_LSB = 0;
  localparam int RATE_WIDTH = 2;
  localparam int BIT_SRC_SEL = 0;
  localparam int MODE_LSB = 1;
  localparam int MODE_WIDTH = 3;
  localparam logic [31:0] MODE_RESET = 32'h0000_0000;
  // ==========================================================
  // Divider taps
  localparam int GEAR_TAP_BASE = 12;
  localparam int SLOW_TAP_BASE = 5;
  localparam int PRESCALE_WIDTH = 12;
  localparam int SLOW_DIV_WIDTH = 5;
  // ==========================================================
  // Operating modes
  typedef enum logic [2:0] {
    BDO_NORMAL,
    BDO_IDLE,
    BDO_SLOW,
    BDO_LIGHT_SLEEP,
    BDO_STOP,
    BDO_DEEP_IDLE,
    BDO_DEEP_SLEEP
  } bdo_mode_t;
  localparam logic [2:0] MODE_STOP_CODE = 3'h4;
endpackage

// ==== hw/bdo_prescaler.sv ====
// Free-running prescaler with gear and slow-clock taps
// Assumes a one-cycle slow tick from the synchroniser
`timescale 1ns/1ns
`default_nettype none
module bdo_prescaler #(
  parameter int GEAR_W = bdo_pkg::PRESCALE_WIDTH,
  parameter int SLOW_W = bdo_pkg::SLOW_DIV_WIDTH
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Slow tick and taps
  input wire logic i_slow_tick,
  output logic [GEAR_W-1:0] o_gear_count,
  output logic [SLOW_W-1:0] o_slow_count
);
  logic [GEAR_W-1:0] gear_count;
  logic [GEAR_W-1:0] next_gear_count;
  logic [SLOW_W-1:0] slow_count;
  logic [SLOW_W-1:0] next_slow_count;

  // ==========================================================
  // Counters run regardless of the output enable
  always_comb begin
    next_gear_count = gear_count + {{(GEAR_W-1){1'b0}}, 1'b1};
    next_slow_count = slow_count;
    if (i_slow_tick) begin
      next_slow_count = slow_count + {{(SLOW_W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      gear_count <= '0;
      slow_count <= '0;
    end else begin
      gear_count <= next_gear_count;
      slow_count <= next_slow_count;
    end
  end

  assign o_gear_count = gear_count;
  assign o_slow_count = slow_count;
endmodule // bdo_prescaler
`default_nettype wire

// ==== hw/bdo_sync.sv ====
// Three-stage synchroniser for the low-frequency clock pin
// Assumes the pin is asynchronous to i_clk
`timescale 1ns/1ns
`default_nettype none
module bdo_sync (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Pin and result
  input wire logic i_pin,
  output logic o_level,
  output logic o_rise
);
  logic [2:0] stage;
  logic [2:0] next_stage;
  logic level;
  logic next_level;

  always_comb begin
    next_stage = {stage[1:0], i_pin};
    next_level = level;
    // Change counts only once second and third stage agree
    if (stage[1] == stage[2]) begin
      next_level = stage[2];
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      stage <= 3'h0;
      level <= 1'b0;
    end else begin
      stage <= next_stage;
      level <= next_level;
    end
  end

  assign o_level = level;
  assign o_rise = next_level & ~level;
endmodule // bdo_sync
`default_nettype wire

// ==== hw/bdo_top.sv ====
// Buzzer divider output: APB control register and tone pin
// Assumes i_clk is the gear clock and an APB master drives the bus
// Notes on behaviour
// - Tone output is a square wave with about 50% duty.
// - Gear source: rate codes 0..3 divide gear clock by 2^12..2^9.
// - Slow source: codes 0..2 divide slow clock by 2^5..2^3; 3 reserved.
// - Enable bit 1 lets the wave out, 0 blocks it.
// - While enabled the active-low pin carries the selected wave.
// - While disabled the pin rests high.
// - Entering stop or deep modes clears enable, keeps rate select.
// - Such mode entry returns the pin high.
// - Prescaler runs regardless of enable; first pulse may be short.
// - Mode entry mid-cycle may leave a truncated last pulse.
// - Normal/slow switches may give odd periods meanwhile.
// - Slow source in normal mode jitters by synchronisation.
// - Control bits seven to three read as zero.
//
// Implementation choice: the APB register port.
`timescale 1ns/1ns
`default_nettype none
module bdo_top (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Clock sources
  input wire logic i_low_freq_clock,
  // Tone pin
  output logic o_tone_out_n
);
  localparam int GW = bdo_pkg::PRESCALE_WIDTH;
  localparam int SW = bdo_pkg::SLOW_DIV_WIDTH;

  logic tone_output_enable;
  logic next_tone_output_enable;
  logic [1:0] tone_rate_select;
  logic [1:0] next_tone_rate_select;
  logic slow_clock_source_select;
  logic next_slow_clock_source_select;
  bdo_pkg::bdo_mode_t mode;
  bdo_pkg::bdo_mode_t next_mode;
  logic tone_out_n;
  logic next_tone_out_n;
  logic [31:0] prdata;
  logic [31:0] next_prdata;
  logic slow_tick;
  logic [GW-1:0] gear_count;
  logic [SW-1:0] slow_count;
  logic use_slow;
  logic tap;
  logic wr;
  logic rd;
  logic hit_ctrl;
  logic hit_mode;
  logic deep_entry;

  // ==========================================================
  // Clock sources
  // Slow clock sampled into the gear domain, hence some jitter
  bdo_sync u_sync (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_pin(i_low_freq_clock),
    .o_level(),
    .o_rise(slow_tick)
  );

  bdo_prescaler #(
    .GEAR_W(GW),
    .SLOW_W(SW)
  ) u_pre (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_slow_tick(slow_tick),
    .o_gear_count(gear_count),
    .o_slow_count(slow_count)
  );

  // ==========================================================
  // Tap select
  // Slow modes always take the slow clock; switching taps mid-period
  // gives one odd period, accepted rather than resynchronising.
  always_comb begin
    use_slow = slow_clock_source_select ||
      (mode == bdo_pkg::BDO_SLOW) ||
      (mode == bdo_pkg::BDO_LIGHT_SLEEP);
    tap = 1'b0;
    if (use_slow) begin
      case (tone_rate_select)
        2'h0: tap = slow_count[bdo_pkg::SLOW_TAP_BASE-1];
        2'h1: tap = slow_count[bdo_pkg::SLOW_TAP_BASE-2];
        2'h2: tap = slow_count[bdo_pkg::SLOW_TAP_BASE-3];
        default: tap = 1'b0;
      endcase
    end else begin
      // Counter bit n toggles every 2^n cycles: 50% duty square wave
      case (tone_rate_select)
        2'h0: tap = gear_count[bdo_pkg::GEAR_TAP_BASE-1];
        2'h1: tap = gear_count[bdo_pkg::GEAR_TAP_BASE-2];
        2'h2: tap = gear_count[bdo_pkg::GEAR_TAP_BASE-3];
        default: tap = gear_count[bdo_pkg::GEAR_TAP_BASE-4];
      endcase
    end
  end

  // ==========================================================
  // APB decode
  // Zero wait states; unmapped addresses read zero with pslverr
  always_comb begin
    wr = i_psel && i_penable && i_pwrite;
    rd = i_psel && !i_penable && !i_pwrite;
    hit_ctrl = (i_paddr == bdo_pkg::ADDR_CONTROL);
    hit_mode = (i_paddr == bdo_pkg::ADDR_MODE);
  end

  // ==========================================================
  // Control and mode registers
  always_comb begin
    next_tone_output_enable = tone_output_enable;
    next_tone_rate_select = tone_rate_select;
    next_slow_clock_source_select = slow_clock_source_select;
    next_mode = mode;
    deep_entry = 1'b0;
    if (wr && hit_ctrl) begin
      next_tone_output_enable = i_pwdata[bdo_pkg::BIT_ENABLE];
      next_tone_rate_select =
        i_pwdata[bdo_pkg::RATE_LSB +: bdo_pkg::RATE_WIDTH];
    end
    if (wr && hit_mode) begin
      next_slow_clock_source_select = i_pwdata[bdo_pkg::BIT_SRC_SEL];
      case (i_pwdata[bdo_pkg::MODE_LSB +: bdo_pkg::MODE_WIDTH])
        3'h0: next_mode = bdo_pkg::BDO_NORMAL;
        3'h1: next_mode = bdo_pkg::BDO_IDLE;
        3'h2: next_mode = bdo_pkg::BDO_SLOW;
        3'h3: next_mode = bdo_pkg::BDO_LIGHT_SLEEP;
        3'h4: next_mode = bdo_pkg::BDO_STOP;
        3'h5: next_mode = bdo_pkg::BDO_DEEP_IDLE;
        3'h6: next_mode = bdo_pkg::BDO_DEEP_SLEEP;
        default: next_mode = mode;
      endcase
    end
    // Mode entry overrides a same-cycle enable write
    deep_entry = (next_mode != mode) &&
      ((next_mode == bdo_pkg::BDO_STOP) ||
       (next_mode == bdo_pkg::BDO_DEEP_IDLE) ||
       (next_mode == bdo_pkg::BDO_DEEP_SLEEP));
    if (deep_entry) begin
      next_tone_output_enable = 1'b0;
    end
  end

  // ==========================================================
  // Tone pin
  // Gating with no resync: a truncated last pulse is allowed
  always_comb begin
    next_tone_out_n = 1'b1;
    if (tone_output_enable) begin
      next_tone_out_n = ~tap;
    end
  end

  // ==========================================================
  // Read data
  always_comb begin
    next_prdata = 32'h0000_0000;
    if (rd && hit_ctrl) begin
      next_prdata[bdo_pkg::BIT_ENABLE] = tone_output_enable;
      next_prdata[bdo_pkg::RATE_LSB +: bdo_pkg::RATE_WIDTH] =
        tone_rate_select;
    end else if (rd && hit_mode) begin
      next_prdata[bdo_pkg::BIT_SRC_SEL] = slow_clock_source_select;
      next_prdata[bdo_pkg::MODE_LSB +: bdo_pkg::MODE_WIDTH] = mode;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      tone_output_enable <= bdo_pkg::CONTROL_RESET[bdo_pkg::BIT_ENABLE];
      tone_rate_select <= bdo_pkg::CONTROL_RESET[1:0];
      slow_clock_source_select <= bdo_pkg::MODE_RESET[0];
      mode <= bdo_pkg::BDO_NORMAL;
      tone_out_n <= 1'b1;
      prdata <= 32'h0000_0000;
    end else begin
      tone_output_enable <= next_tone_output_enable;
      tone_rate_select <= next_tone_rate_select;
      slow_clock_source_select <= next_slow_clock_source_select;
      mode <= next_mode;
      tone_out_n <= next_tone_out_n;
      if (i_psel && !i_penable) begin
        prdata <= next_prdata;
      end
    end
  end

  assign o_prdata = prdata;
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel && i_penable && !hit_ctrl && !hit_mode;
  assign o_tone_out_n = tone_out_n;
endmodule // bdo_top
`default_nettype wire

// ==== test/bdo_buzzer.sv ====
// Buzzer load and free-running slow crystal
// Assumes an active-low tone pin
`timescale 1ns/1ns
`default_nettype none
module bdo_buzzer #(
  parameter int HALF_NS = 473
) (
  // Buzzer load
  input wire logic i_tone_n,
  // Crystal and pulse count
  output logic o_lf_clk,
  output var int o_pulses
);
  // ========
  // Odd half period keeps the phase drifting
  initial o_lf_clk = 1'h0;
  always #(HALF_NS) o_lf_clk = ~o_lf_clk;
  initial o_pulses = 0;
  always @(negedge i_tone_n) o_pulses = o_pulses + 1;
endmodule // bdo_buzzer
`default_nettype wire

// ==== test/bdo_top_sva.sv ====
// Assertions on the divider output ports
// Bound to bdo_top; one clock domain
`timescale 1ns/1ns
`default_nettype none
module bdo_top_sva (
  // Clock, reset, bus
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  // Tone pin
  input wire logic o_tone_out_n
);
  // ========
  // Register shadow and tone timing
  logic wc, wm, rc, dp, gear, slow, chg, tq, ed, clr;
  logic [2:0] ctl;
  logic [3:0] md;
  logic [1:0] sn;
  logic [11:0] cnt;
  logic [12:0] wt;
  assign wc = i_psel && i_penable && i_pwrite && i_paddr == 12'h038;
  assign wm = i_psel && i_penable && i_pwrite && i_paddr == 12'h03c;
  assign rc = i_psel && i_penable && !i_pwrite && i_paddr == 12'h038;
  // Rewriting the same deep mode must not clear
  assign dp = wm && i_pwdata[3:1] != md[3:1] && i_pwdata[3:1] > 3'h3
    && i_pwdata[3:1] != 3'h7;
  assign gear = !md[0] && md[3:1] < 3'h2;
  assign slow = md[0] || md[3:1] == 3'h2 || md[3:1] == 3'h3;
  assign chg = o_tone_out_n != tq;
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      {ctl, md, sn, cnt, ed, clr, wt} <= '0;
      tq <= 1'h1;
    end else begin
      tq <= o_tone_out_n;
      ed <= ctl[2];
      cnt <= chg ? 12'h000 : cnt + 12'h001;
      // Cycles since the pin last moved while on in a gear mode
      wt <= (chg || !ctl[2] || !gear) ? 13'h0000 : wt + {12'h000, !(&wt)};
      // Two edges after a write before periods are trusted
      sn <= (wc || wm) ? 2'h0 : sn + {1'h0, chg && sn != 2'h2};
      if (wc) ctl <= i_pwdata[2:0];
      if (wm) md[0] <= i_pwdata[0];
      if (wm && i_pwdata[3:1] != 3'h7) md[3:1] <= i_pwdata[3:1];
      if (dp) ctl[2] <= 1'h0;
      if (wc || dp) clr <= dp;
    end
  end
  // ========
  // Properties
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  // Counter, not a long delay range: worst gap is two half periods
  sequence s_on; ctl[2] && gear; endsequence
  property p_wave; s_on |-> wt < 13'h1004; endproperty
  a_wave: assert property (p_wave) else $error("no wave");
  property p_half; chg && sn == 2'h2 && ed && ctl[2] && gear
    |-> cnt == (12'h800 >> ctl[1:0]) - 12'h001; endproperty
  a_half: assert property (p_half) else $error("bad half");
  property p_idle; !ctl[2] && !ed |-> o_tone_out_n; endproperty
  a_idle: assert property (p_idle) else $error("low while off");
  property p_off; dp |=> ##1 o_tone_out_n; endproperty
  a_off: assert property (p_off) else $error("low after deep");
  property p_rsv; (slow && ctl[1:0] == 2'h3)[*2] |-> o_tone_out_n; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved rate");
  property p_rd0; rc |-> o_prdata[31:3] == 29'h0; endproperty
  a_rd0: assert property (p_rd0) else $error("upper bits set");
  property p_back; rc |-> o_prdata[2:0] == ctl; endproperty
  a_back: assert property (p_back) else $error("readback");
  property p_keep; rc && clr |-> o_prdata[2:0] == {1'h0, ctl[1:0]};
  endproperty
  a_keep: assert property (p_keep) else $error("deep clear");
endmodule // bdo_top_sva
bind bdo_top bdo_top_sva bdo_top_sva_inst (.i_clk, .i_resetn, .i_psel,
  .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_tone_out_n);
`default_nettype wire

// ==== test/tb_top.sv ====
// Testbench for the divider output block
// Assumes the bound checker and the buzzer model
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic clk = 1'h0;
  logic resetn = 1'h0;
  logic psel = 1'h0;
  logic pen = 1'h0;
  logic pwr = 1'h0;
  logic [11:0] pa = 12'h000;
  logic [31:0] wd = 32'h0;
  logic [31:0] rd, q;
  logic rdy, err, e, tone, lfck;
  int pulses, errors, compares, h, l, p;
  always #5 clk = ~clk;
  bdo_top bdo_top_inst (.i_clk(clk), .i_resetn(resetn), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(pa), .i_pwdata(wd),
    .o_prdata(rd), .o_pready(rdy), .o_pslverr(err),
    .i_low_freq_clock(lfck), .o_tone_out_n(tone));
  bdo_buzzer bdo_buzzer_inst (.i_tone_n(tone), .o_lf_clk(lfck),
    .o_pulses(pulses));
  task automatic summarize;
    $display("compares=%0d errors=%0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    compares++;
    if (g !== x) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input int d);
    int n;
    n = 0;
    @(posedge clk);
    {psel, pwr, pa, wd} <= {1'h1, w, a, d};
    @(posedge clk);
    pen <= 1'h1;
    do begin
      @(posedge clk);
      n++;
    end while (rdy !== 1'h1 && n < 20);
    q = rd;
    e = err;
    {psel, pen} <= 2'h0;
    if (rdy !== 1'h1) begin
      errors++;
      summarize();
    end
  endtask
  // Cycles until the pin next changes
  task automatic tgl(output int n);
    logic t;
    t = tone;
    n = 0;
    // Sample mid-cycle, where the registered pin has settled
    do begin
      @(negedge clk);
      n++;
    end while (tone === t && n < 9000);
    if (tone === t) begin
      errors++;
      summarize();
    end
  endtask
  task automatic t_regs;
    apb(1'h0, 12'h038, 0);
    chk(q, 32'h0);
    apb(1'h1, 12'h038, -1);
    apb(1'h0, 12'h038, 0);
    chk(q, 32'h7);
    apb(1'h0, 12'h040, 0);
    chk({q[30:0], e}, 32'h1);
    $display("regs done");
  endtask
  // Skip two edges: the first after a change may be short
  task automatic t_wave(input int sh, input int n);
    int x;
    for (int r = 0; r < n; r++) begin
      apb(1'h1, 12'h038, 4 + r);
      tgl(h);
      tgl(h);
      tgl(h);
      tgl(l);
      if (sh == 0) chk(h, 32'h800 >> r);
      if (sh == 0) chk(l, 32'h800 >> r);
      // Slow period in ns times 2^(5-r) slow cycles, 10 ns per clock
      x = sh * (32 >> r) / 10;
      // Slow source jitters by a few cycles
      if (sh) chk(h + l + 2 >= x && h + l <= x + 2, 1);
    end
    $display("wave done");
  endtask
  task automatic t_off(input int m);
    apb(1'h1, 12'h03c, m);
    apb(1'h1, 12'h038, 3 + m * 4);
    repeat (2) @(posedge clk);
    p = pulses;
    repeat (4000) @(posedge clk);
    @(negedge clk);
    chk(pulses, p);
    chk(tone, 1);
    $display("off done");
  endtask
  task automatic t_deep;
    for (int m = 4; m < 7; m++) begin
      apb(1'h1, 12'h03c, 0);
      apb(1'h1, 12'h038, 6);
      tgl(h);
      if (tone === 1'h1) tgl(h);
      apb(1'h1, 12'h03c, m * 2);
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk(tone, 1);
      apb(1'h0, 12'h038, 0);
      chk(q, 32'h2);
    end
    $display("deep done");
  endtask
  // Light sleep takes the slow clock; mode code 7 keeps the mode
  task automatic t_mode;
    apb(1'h1, 12'h03c, 6);
    apb(1'h1, 12'h038, 7);
    apb(1'h0, 12'h03c, 0);
    chk(q, 32'h6);
    p = pulses;
    repeat (300) @(posedge clk);
    @(negedge clk);
    chk(pulses, p);
    apb(1'h1, 12'h03c, 15);
    apb(1'h0, 12'h03c, 0);
    chk(q, 32'h7);
    apb(1'h1, 12'h03c, 2);
    apb(1'h0, 12'h03c, 0);
    chk(q, 32'h2);
    $display("mode done");
  endtask
  initial begin
    errors = 0;
    compares = 0;
    repeat (2) @(posedge clk);
    resetn <= 1'h1;
    t_regs();
    t_wave(0, 4);
    t_off(0);
    apb(1'h1, 12'h03c, 4);
    // 946 ns: slow clock period of the buzzer model
    t_wave(946, 3);
    t_off(1);
    t_deep();
    t_mode();
    summarize();
  end
endmodule // tb_top
`default_nettype wire
